// ---- hlax_helio_ctrl.sv ----
// heliostat controller end: encoder counting, motor control, bus replies
// assumes encoder, manual and address pins are asynchronous to core_clk
`timescale 1ns/100ps
// Notes on behaviour
// - drive bus only while sending a reply
// - receiver listening to the pair except while sending
// - each axis: slew, track or off only
// - motor on when run is set and target differs from position
// - large error slews, small error tracks
// - direction relay changes only with motor off
// - two quadrature tracks per axis, 13-bit count
// - every legal track change updates stored axis count
// - power-up reset, motors held off during init
// - watchdog forces reinit when loop stalls
// - field controller sends sun vector each second
// - field controller sends axis targets only when commanded
// - one bus, 32 units, own address only
// - answer each own poll with status frame
// - one pair both ways, no overlapping drivers
// - self-check failure reported in status
// - manual unit overrides bus positioning
module hlax_helio_ctrl #(
  parameter int BIT_CYC     = hlax_pkg::BIT_CYC,
  parameter int INIT_CYC    = hlax_pkg::INIT_CYC,
  parameter int WD_CYC      = hlax_pkg::WD_CYC,
  parameter int STALE_CYC   = hlax_pkg::STALE_CYC,
  parameter int SLEW_THRESH = hlax_pkg::SLEW_THRESH
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  hlax_bus_if.dev                          bus,
  input  wire logic [hlax_pkg::ADDR_W-1:0] my_addr,
  input  wire logic [1:0]                  enc_a,
  input  wire logic [1:0]                  enc_b,
  input  wire logic                        manual_present,
  input  wire logic [1:0]                  manual_fwd,
  input  wire logic [1:0]                  manual_rev,
  output logic [1:0]                       mot_slew,
  output logic [1:0]                       mot_track,
  output logic [1:0]                       mot_dir,
  output logic                             fault
);
  localparam int CW = $clog2(BIT_CYC);
  localparam int IW = $clog2(INIT_CYC + 1);
  localparam int WW = $clog2(WD_CYC + 1);
  localparam int SW = $clog2(STALE_CYC + 1);
  localparam int TW = $clog2(hlax_pkg::TURN_CYC + 1);
  localparam int NP = 2 * hlax_pkg::NAXIS + 2 * hlax_pkg::NAXIS + 2 + hlax_pkg::ADDR_W;
  localparam int EW = hlax_pkg::ERR_W;

  // {bad, move, up} from previous and current {a,b}
  function automatic logic [2:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    logic [2:0] r;
    r = 3'h0;
    if ((p ^ c) == 2'h3)
      r = 3'h4;
    else if (p != c)
      r = {1'b0, 1'b1, p[1] ^ c[0]};
    return r;
  endfunction

  logic [NP-1:0]               pin_s1_r, pin_s2_r;
  logic [1:0]                  ea_s, eb_s, mf_s, mr_s;
  logic                        man_s, line_s;
  logic [hlax_pkg::ADDR_W-1:0] addr_s;
  logic [1:0]                  enc_prev_r [hlax_pkg::NAXIS];
  logic [hlax_pkg::POS_W-1:0]  pos_r [hlax_pkg::NAXIS];
  logic [hlax_pkg::POS_W-1:0]  tgt_r [hlax_pkg::NAXIS];
  logic [hlax_pkg::ERR_W-1:0]  err [hlax_pkg::NAXIS];
  logic [hlax_pkg::ERR_W-1:0]  mag [hlax_pkg::NAXIS];
  logic                        enc_bad;
  logic [2:0]                  qs [hlax_pkg::NAXIS];
  logic [1:0]                  prime_r;
  logic [IW-1:0]               init_r;
  logic [WW-1:0]               wd_r;
  logic                        wd_trip, hold, kick;
  hlax_pkg::hlax_ctl_t         ctl_r;
  logic [1:0]                  want_on_r, want_dir_r, want_big_r;
  logic [1:0]                  slew_r, track_r, dir_r;
  logic                        run_r, fail_r, sel_r, rep_pend_r, rep_go;
  logic [TW-1:0]               turn_r;
  logic [SW-1:0]               stale_r;
  logic                        stale;
  logic                        rx_busy_r, rx_done_r, for_me, is_sun;
  logic [CW-1:0]               rx_cnt_r;
  logic [4:0]                  rx_bit_r;
  logic [hlax_pkg::FRAME_W-1:0] rx_sh_r;
  logic [hlax_pkg::OP_W-1:0]   rx_op;
  logic [hlax_pkg::DATA_W-1:0] rx_data, st_data;
  logic                        tx_act_r;
  logic [CW-1:0]               tx_cnt_r;
  logic [4:0]                  tx_bit_r;
  logic [hlax_pkg::LINE_W-1:0] tx_sh_r;

  assign mot_slew   = slew_r;
  assign mot_track  = track_r;
  assign mot_dir    = dir_r;
  assign fault      = fail_r;
  assign bus.dev_o  = tx_sh_r[hlax_pkg::LINE_W-1];
  assign bus.dev_oe = tx_act_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
    end else begin
      pin_s1_r <= {my_addr, bus.line, manual_present, manual_rev, manual_fwd, enc_b, enc_a};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {addr_s, line_s, man_s, mr_s, mf_s, eb_s, ea_s} = pin_s2_r;

  always_comb begin
    for (int i = 0; i < hlax_pkg::NAXIS; i++)
      qs[i] = quad_step(enc_prev_r[i], {ea_s[i], eb_s[i]});
  end

  // every legal edge moves the count; a double jump is a self-check failure
  // no counting until the sync stages hold real pin samples, else a false jump
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_prev_r <= '{default: 2'h0};
      pos_r      <= '{default: hlax_pkg::POS_RST};
      enc_bad    <= 1'b0;
      prime_r    <= 2'h0;
    end else begin
      enc_bad <= 1'b0;
      if (prime_r != 2'h3)
        prime_r <= prime_r + 2'h1;
      for (int i = 0; i < hlax_pkg::NAXIS; i++) begin
        enc_prev_r[i] <= {ea_s[i], eb_s[i]};
        if (prime_r == 2'h3 && qs[i][2])
          enc_bad <= 1'b1;
        else if (prime_r == 2'h3 && qs[i][1])
          pos_r[i] <= qs[i][0] ? pos_r[i] + 1'b1 : pos_r[i] - 1'b1;
      end
    end
  end

  // init hold after reset and after a watchdog trip
  assign hold    = init_r != '0;
  assign wd_trip = wd_r == WW'(WD_CYC);
  assign kick    = ctl_r == hlax_pkg::CTL_DRV;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r <= IW'(INIT_CYC);
      wd_r   <= '0;
    end else begin
      wd_r <= (kick || wd_trip) ? '0 : wd_r + 1'b1;
      if (wd_trip)
        init_r <= IW'(INIT_CYC);
      else if (hold)
        init_r <= init_r - 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < hlax_pkg::NAXIS; i++) begin
      err[i] = {1'b0, tgt_r[i]} - {1'b0, pos_r[i]};
      mag[i] = err[i][hlax_pkg::ERR_W-1] ? EW'(0) - err[i] : err[i];
    end
  end

  assign rx_op   = rx_sh_r[hlax_pkg::DATA_W +: hlax_pkg::OP_W];
  assign rx_data = rx_sh_r[hlax_pkg::DATA_W-1:0];
  assign is_sun  = rx_done_r && rx_op == hlax_pkg::OP_SUN;
  assign for_me  = rx_done_r
                   && rx_sh_r[hlax_pkg::FRAME_W-1 -: hlax_pkg::ADDR_W] == addr_s;
  assign stale   = stale_r == SW'(STALE_CYC);
  assign rep_go  = rep_pend_r && turn_r == '0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_r      <= '{default: hlax_pkg::POS_RST};
      run_r      <= 1'b0;
      fail_r     <= 1'b0;
      sel_r      <= 1'b0;
      rep_pend_r <= 1'b0;
      turn_r     <= '0;
      stale_r    <= '0;
    end else begin
      stale_r <= is_sun ? '0 : (stale ? stale_r : stale_r + 1'b1);
      // set wins over a clear in the same cycle
      fail_r <= wd_trip || enc_bad || (fail_r && !(for_me && rx_op == hlax_pkg::OP_CMD
                                                   && rx_data[hlax_pkg::CMD_CLR]));
      if (hold || wd_trip) begin
        run_r <= 1'b0;
        tgt_r <= pos_r;
      end else if (man_s) begin
        tgt_r <= pos_r;
      end else if (for_me && rx_op == hlax_pkg::OP_TGT_AZ) begin
        tgt_r[0] <= rx_data[hlax_pkg::POS_W-1:0];
      end else if (for_me && rx_op == hlax_pkg::OP_TGT_EL) begin
        tgt_r[1] <= rx_data[hlax_pkg::POS_W-1:0];
      end else if (for_me && rx_op == hlax_pkg::OP_CMD) begin
        run_r <= rx_data[hlax_pkg::CMD_RUN];
      end
      if (for_me && rx_op == hlax_pkg::OP_POLL) begin
        rep_pend_r <= 1'b1;
        sel_r      <= rx_data[0];
        turn_r     <= TW'(hlax_pkg::TURN_CYC);
      end else if (rep_go) begin
        rep_pend_r <= 1'b0;
      end else if (turn_r != '0) begin
        turn_r <= turn_r - 1'b1;
      end
    end
  end

  assign st_data = {fail_r, man_s, stale, pos_r[sel_r]};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r      <= hlax_pkg::CTL_IDLE;
      want_on_r  <= '0;
      want_dir_r <= '0;
      want_big_r <= '0;
      slew_r     <= '0;
      track_r    <= '0;
      dir_r      <= '0;
    end else begin
      case (ctl_r)
        hlax_pkg::CTL_IDLE: ctl_r <= hlax_pkg::CTL_CMP;
        hlax_pkg::CTL_CMP: begin
          ctl_r <= hlax_pkg::CTL_DRV;
          for (int i = 0; i < hlax_pkg::NAXIS; i++) begin
            if (hold) begin
              want_on_r[i] <= 1'b0;
            end else if (man_s) begin
              want_on_r[i]  <= mf_s[i] ^ mr_s[i];
              want_dir_r[i] <= mf_s[i];
              want_big_r[i] <= 1'b0;
            end else begin
              want_on_r[i]  <= run_r && err[i] != '0;
              want_dir_r[i] <= !err[i][hlax_pkg::ERR_W-1];
              want_big_r[i] <= mag[i] > EW'(SLEW_THRESH);
            end
          end
        end
        hlax_pkg::CTL_DRV: begin
          ctl_r <= hlax_pkg::CTL_IDLE;
          for (int i = 0; i < hlax_pkg::NAXIS; i++) begin
            if (want_on_r[i] && want_dir_r[i] != dir_r[i]) begin
              // stop first; relay moves one pass later with no current
              slew_r[i]  <= 1'b0;
              track_r[i] <= 1'b0;
              if (!slew_r[i] && !track_r[i])
                dir_r[i] <= want_dir_r[i];
            end else begin
              slew_r[i]  <= want_on_r[i] && want_big_r[i];
              track_r[i] <= want_on_r[i] && !want_big_r[i];
            end
          end
        end
        default: ctl_r <= ctl_r;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_r <= 1'b0;
      tx_cnt_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r  <= '1;
    end else if (!tx_act_r) begin
      if (rep_go) begin
        tx_act_r <= 1'b1;
        tx_sh_r  <= {1'b0, hlax_pkg::hlax_frame(addr_s, hlax_pkg::OP_STATUS, st_data), 1'b1};
        tx_cnt_r <= CW'(BIT_CYC - 1);
        tx_bit_r <= '0;
      end
    end else if (tx_cnt_r == '0) begin
      tx_cnt_r <= CW'(BIT_CYC - 1);
      tx_sh_r  <= {tx_sh_r[hlax_pkg::LINE_W-2:0], 1'b1};
      tx_bit_r <= tx_bit_r + 5'h01;
      if (tx_bit_r == 5'(hlax_pkg::STOP_IDX))
        tx_act_r <= 1'b0;
    end else begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_cnt_r  <= '0;
      rx_bit_r  <= '0;
      rx_sh_r   <= '0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!line_s && !tx_act_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= CW'(BIT_CYC / 2);
          rx_bit_r  <= '0;
        end
      end else if (rx_cnt_r == '0) begin
        rx_cnt_r <= CW'(BIT_CYC - 1);
        rx_bit_r <= rx_bit_r + 5'h01;
        if (rx_bit_r == 5'h00 && line_s) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r == 5'(hlax_pkg::STOP_IDX)) begin
          rx_busy_r <= 1'b0;
          rx_done_r <= line_s;
        end else begin
          rx_sh_r <= {rx_sh_r[hlax_pkg::FRAME_W-2:0], line_s};
        end
      end else begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end
    end
  end

endmodule // hlax_helio_ctrl

// ---- hlax_pkg.sv ----
// shared constants, types and frame packing for the heliostat axis controller
// assumes a 20 MHz core clock at both ends of the shared bus pair
package hlax_pkg;

  localparam int CLK_HZ       = 20_000_000;
  localparam int BIT_CYC      = 20;
  localparam int ADDR_W       = 5;
  localparam int OP_W         = 3;
  localparam int DATA_W       = 16;
  localparam int FRAME_W      = ADDR_W + OP_W + DATA_W;
  localparam int LINE_W       = FRAME_W + 2;
  localparam int STOP_IDX     = FRAME_W + 1;
  localparam int POS_W        = 13;
  localparam int ERR_W        = POS_W + 1;
  localparam int NAXIS        = 2;
  localparam int MAX_UNITS    = 32;
  localparam int SLEW_THRESH  = 32;

  localparam int SUN_PERIOD_S   = 1;
  localparam int SUN_PERIOD_CYC = SUN_PERIOD_S * CLK_HZ;
  localparam int STALE_S        = 3;
  localparam int STALE_CYC      = STALE_S * CLK_HZ;
  localparam int INIT_US        = 1000;
  localparam int INIT_CYC       = INIT_US * (CLK_HZ / 1_000_000);
  localparam int WD_MS          = 100;
  localparam int WD_CYC         = WD_MS * (CLK_HZ / 1000);
  localparam int TURN_CYC       = 4 * BIT_CYC;
  localparam int RSP_WAIT_CYC   = 2 * TURN_CYC + (LINE_W + 2) * BIT_CYC;

  localparam int ST_FAIL  = 15;
  localparam int ST_MAN   = 14;
  localparam int ST_STALE = 13;
  localparam int CMD_RUN  = 0;
  localparam int CMD_CLR  = 1;

  localparam logic [POS_W-1:0] POS_RST = 13'h0000;

  typedef enum logic [OP_W-1:0] {
    OP_SUN    = 3'h0,
    OP_TGT_AZ = 3'h1,
    OP_TGT_EL = 3'h2,
    OP_POLL   = 3'h3,
    OP_CMD    = 3'h4,
    OP_STATUS = 3'h5
  } hlax_op_t;

  typedef enum logic [1:0] {
    CTL_IDLE = 2'h0,
    CTL_CMP  = 2'h1,
    CTL_DRV  = 2'h3
  } hlax_ctl_t;

  typedef enum logic [1:0] {
    FC_IDLE = 2'h0,
    FC_SEND = 2'h1,
    FC_WAIT = 2'h3,
    FC_GAP  = 2'h2
  } hlax_fc_t;

  function automatic logic [FRAME_W-1:0] hlax_frame(input logic [ADDR_W-1:0] a,
                                                    input logic [OP_W-1:0]   o,
                                                    input logic [DATA_W-1:0] d);
    return {a, o, d};
  endfunction

endpackage

// ---- hlax_bus_if.sv ----
// shared two-wire bus pair between field controller and heliostat controllers
// assumes the pair idles high; a unit pulls it only while its enable is high
`timescale 1ns/100ps
interface hlax_bus_if;
  logic dev_o;
  logic dev_oe;
  logic fc_o;
  logic fc_oe;
  logic line;

  assign line = (dev_oe ? dev_o : 1'b1) & (fc_oe ? fc_o : 1'b1);

  modport dev (output dev_o, output dev_oe, input line);
  modport fc  (output fc_o, output fc_oe, input line);
endinterface

// ---- hlax_field_ctrl.sv ----
// field controller end: sends sun, target, command and poll frames
// assumes one controller per bus and up to 32 heliostat controllers on it
`timescale 1ns/100ps
module hlax_field_ctrl #(
  parameter int SEC_CYC = hlax_pkg::SUN_PERIOD_CYC,
  parameter int BIT_CYC = hlax_pkg::BIT_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  hlax_bus_if.fc                          bus,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic [hlax_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [hlax_pkg::OP_W-1:0]  cmd_op,
  input  wire logic [hlax_pkg::DATA_W-1:0] cmd_data,
  input  wire logic [hlax_pkg::DATA_W-1:0] sun_data,
  output logic                            sec_tick,
  output logic                            rsp_valid,
  output logic [hlax_pkg::ADDR_W-1:0]     rsp_addr,
  output logic [hlax_pkg::DATA_W-1:0]     rsp_data,
  output logic                            rsp_timeout
);
  localparam int CW = $clog2(BIT_CYC);
  localparam int SW = $clog2(SEC_CYC);
  localparam int WW = $clog2(hlax_pkg::RSP_WAIT_CYC + 1);

  logic                            line_s1_r, line_s2_r;
  logic [SW-1:0]                   sec_cnt_r;
  logic                            sec_r, sun_pend_r, rdy_r;
  hlax_pkg::hlax_fc_t              st_r;
  logic [WW-1:0]                   wait_r;
  logic                            is_poll_r;
  logic [hlax_pkg::ADDR_W-1:0]     dst_r;
  logic                            tx_act_r, tx_go;
  logic [CW-1:0]                   tx_cnt_r;
  logic [4:0]                      tx_bit_r;
  logic [hlax_pkg::LINE_W-1:0]     tx_sh_r;
  logic [hlax_pkg::FRAME_W-1:0]    tx_frame;
  logic                            rx_busy_r, rx_done_r;
  logic [CW-1:0]                   rx_cnt_r;
  logic [4:0]                      rx_bit_r;
  logic [hlax_pkg::FRAME_W-1:0]    rx_sh_r;
  logic                            vld_r, tmo_r;
  logic [hlax_pkg::ADDR_W-1:0]     raddr_r;
  logic [hlax_pkg::DATA_W-1:0]     rdata_r;

  assign cmd_ready   = rdy_r;
  assign sec_tick    = sec_r;
  assign rsp_valid   = vld_r;
  assign rsp_addr    = raddr_r;
  assign rsp_data    = rdata_r;
  assign rsp_timeout = tmo_r;
  assign bus.fc_o    = tx_sh_r[hlax_pkg::LINE_W-1];
  assign bus.fc_oe   = tx_act_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_s1_r <= 1'b1;
      line_s2_r <= 1'b1;
    end else begin
      line_s1_r <= bus.line;
      line_s2_r <= line_s1_r;
    end
  end

  // sun vector goes out once a second; a tick landing on the take still wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_r  <= '0;
      sec_r      <= 1'b0;
      sun_pend_r <= 1'b0;
    end else begin
      sec_r <= (sec_cnt_r == SW'(SEC_CYC - 1));
      sec_cnt_r <= (sec_cnt_r == SW'(SEC_CYC - 1)) ? '0 : sec_cnt_r + 1'b1;
      if (sec_r)
        sun_pend_r <= 1'b1;
      else if (tx_go && st_r == hlax_pkg::FC_IDLE && sun_pend_r)
        sun_pend_r <= 1'b0;
    end
  end

  assign tx_go = (st_r == hlax_pkg::FC_IDLE) && (sun_pend_r || (cmd_valid && !rdy_r));
  assign tx_frame = sun_pend_r ? hlax_pkg::hlax_frame('0, hlax_pkg::OP_SUN, sun_data)
                               : hlax_pkg::hlax_frame(cmd_addr, cmd_op, cmd_data);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= hlax_pkg::FC_IDLE;
      wait_r    <= '0;
      is_poll_r <= 1'b0;
      dst_r     <= '0;
      rdy_r     <= 1'b0;
      vld_r     <= 1'b0;
      tmo_r     <= 1'b0;
      raddr_r   <= '0;
      rdata_r   <= '0;
    end else begin
      rdy_r <= 1'b0;
      vld_r <= 1'b0;
      tmo_r <= 1'b0;
      case (st_r)
        hlax_pkg::FC_IDLE: begin
          if (tx_go) begin
            st_r      <= hlax_pkg::FC_SEND;
            rdy_r     <= !sun_pend_r;
            is_poll_r <= !sun_pend_r && cmd_op == hlax_pkg::OP_POLL;
            dst_r     <= cmd_addr;
          end
        end
        hlax_pkg::FC_SEND: begin
          wait_r <= '0;
          if (!tx_act_r && tx_bit_r != 5'h00)
            st_r <= is_poll_r ? hlax_pkg::FC_WAIT : hlax_pkg::FC_GAP;
        end
        hlax_pkg::FC_WAIT: begin
          wait_r <= wait_r + 1'b1;
          if (rx_done_r && rx_sh_r[hlax_pkg::DATA_W +: hlax_pkg::OP_W] == hlax_pkg::OP_STATUS
              && rx_sh_r[hlax_pkg::FRAME_W-1 -: hlax_pkg::ADDR_W] == dst_r) begin
            vld_r   <= 1'b1;
            raddr_r <= dst_r;
            rdata_r <= rx_sh_r[hlax_pkg::DATA_W-1:0];
            st_r    <= hlax_pkg::FC_GAP;
            wait_r  <= '0;
          end else if (wait_r == WW'(hlax_pkg::RSP_WAIT_CYC)) begin
            tmo_r  <= 1'b1;
            st_r   <= hlax_pkg::FC_GAP;
            wait_r <= '0;
          end
        end
        default: begin
          // quiet gap so a slow responder has released the pair
          wait_r <= wait_r + 1'b1;
          if (wait_r == WW'(hlax_pkg::TURN_CYC))
            st_r <= hlax_pkg::FC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_r <= 1'b0;
      tx_cnt_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r  <= '1;
    end else if (!tx_act_r) begin
      if (tx_go) begin
        tx_act_r <= 1'b1;
        tx_sh_r  <= {1'b0, tx_frame, 1'b1};
        tx_cnt_r <= CW'(BIT_CYC - 1);
        tx_bit_r <= '0;
      end
    end else if (tx_cnt_r == '0) begin
      tx_cnt_r <= CW'(BIT_CYC - 1);
      tx_sh_r  <= {tx_sh_r[hlax_pkg::LINE_W-2:0], 1'b1};
      tx_bit_r <= tx_bit_r + 5'h01;
      if (tx_bit_r == 5'(hlax_pkg::STOP_IDX))
        tx_act_r <= 1'b0;
    end else begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end
  end

  // own echo is ignored while sending
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_cnt_r  <= '0;
      rx_bit_r  <= '0;
      rx_sh_r   <= '0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!line_s2_r && !tx_act_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= CW'(BIT_CYC / 2);
          rx_bit_r  <= '0;
        end
      end else if (rx_cnt_r == '0) begin
        rx_cnt_r <= CW'(BIT_CYC - 1);
        rx_bit_r <= rx_bit_r + 5'h01;
        if (rx_bit_r == 5'h00 && line_s2_r) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r == 5'(hlax_pkg::STOP_IDX)) begin
          rx_busy_r <= 1'b0;
          rx_done_r <= line_s2_r;
        end else begin
          rx_sh_r <= {rx_sh_r[hlax_pkg::FRAME_W-2:0], line_s2_r};
        end
      end else begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end
    end
  end

endmodule // hlax_field_ctrl

// ---- hlax_asserts.sv ----
// checker on the shared bus pair between the two ends
// assumes one heliostat controller and one field controller on the pair
`timescale 1ns/100ps
module hlax_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic fc_o,
  input wire logic fc_oe,
  input wire logic line
);
  logic [9:0] dcnt_r;
  logic [9:0] fcnt_r;
  logic [7:0] quiet_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) dcnt_r <= 10'h000;
    else dcnt_r <= dev_oe ? dcnt_r + 10'h001 : 10'h000;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) fcnt_r <= 10'h000;
    else fcnt_r <= fc_oe ? fcnt_r + 10'h001 : 10'h000;
  end
  // starts saturated so the first frame after reset is legal
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) quiet_r <= 8'hff;
    else if (dev_oe || fc_oe) quiet_r <= 8'h00;
    else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
  end
  a_no_overlap: assert property (!(dev_oe && fc_oe)) else $error("both ends drive");
  a_dev_start: assert property ($rose(dev_oe) |-> !dev_o) else $error("no start bit");
  a_dev_len: assert property ($fell(dev_oe) |-> dcnt_r == 10'h208) else $error("reply len");
  a_dev_stop: assert property ($fell(dev_oe) |-> $past(dev_o)) else $error("reply stop bit");
  a_dev_idle: assert property (!dev_oe |-> dev_o) else $error("idle dev_o low");
  a_fc_len: assert property ($fell(fc_oe) |-> fcnt_r == 10'h208) else $error("frame len");
  a_reply_turn: assert property ($rose(dev_oe) |-> quiet_r >= 8'h3c) else $error("turn");
  a_line_low: assert property (dev_oe && !dev_o |-> !line) else $error("line not low");
  c_reply: cover property ($rose(dev_oe));
  c_frame: cover property ($fell(fc_oe));
  c_turn: cover property ($fell(fc_oe) ##[1:200] $rose(dev_oe));
endmodule // hlax_asserts

// ---- heliostat_axis_controller_tb.sv ----
// testbench joining field controller and heliostat controller over the pair
// assumes both ends use the shortened counts set below
`timescale 1ns/100ps
module heliostat_axis_controller_tb;
  logic core_clk = 0, rst_n = 0, cmd_valid = 0, cmd_ready, sec_tick, rsp_valid, rsp_timeout;
  logic [4:0] cmd_addr = 5'h03, rsp_addr, my_addr = 5'h03;
  logic [2:0] cmd_op = 3'h0;
  logic [15:0] cmd_data = 16'h0000, rsp_data;
  logic [1:0] enc_a = 2'h0, enc_b = 2'h0, manual_fwd = 2'h0, manual_rev = 2'h0;
  logic [1:0] mot_slew, mot_track, mot_dir, pd = 2'h0, pm = 2'h0;
  logic manual_present = 0, fault;
  logic [1:0] g [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int ph [2] = '{0, 0};
  int sec_gap = -1;
  int miscompares = 0, n_compared = 0;
  hlax_bus_if bus ();
  hlax_field_ctrl #(.SEC_CYC(2000)) u_hlax_field_ctrl (.core_clk(core_clk), .rst_n(rst_n),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .sun_data(16'h1234), .sec_tick(sec_tick),
    .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout));
  hlax_helio_ctrl #(.INIT_CYC(16), .WD_CYC(64), .STALE_CYC(20000)) u_hlax_helio_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .my_addr(my_addr), .enc_a(enc_a),
    .enc_b(enc_b), .manual_present(manual_present), .manual_fwd(manual_fwd),
    .manual_rev(manual_rev), .mot_slew(mot_slew), .mot_track(mot_track), .mot_dir(mot_dir),
    .fault(fault));
  hlax_asserts u_hlax_asserts (.core_clk(core_clk), .rst_n(rst_n), .dev_o(bus.dev_o),
    .dev_oe(bus.dev_oe), .fc_o(bus.fc_o), .fc_oe(bus.fc_oe), .line(bus.line));
  initial forever #25 core_clk = ~core_clk;
  task stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tmo();
    miscompares++;
    stop_test();
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // relay may only flip while that axis motor was off; ticks come every SEC_CYC
  always @(negedge core_clk) begin
    if (rst_n && mot_dir !== pd) chk({14'h0, pm & (mot_dir ^ pd)}, 16'h0000);
    if (sec_tick === 1'b1 && sec_gap >= 0) chk(16'(sec_gap), 16'h07cf);
    if (sec_tick === 1'b1) sec_gap = 0;
    else if (sec_gap >= 0) sec_gap++;
    pd <= mot_dir;
    pm <= mot_slew | mot_track;
  end
  task send(input logic [4:0] a, input logic [2:0] o, input logic [15:0] d);
    @(negedge core_clk);
    {cmd_addr, cmd_op, cmd_data, cmd_valid} = {a, o, d, 1'b1};
    repeat (3000) if (cmd_ready !== 1'b1) @(negedge core_clk);
    if (cmd_ready !== 1'b1) tmo();
    @(negedge core_clk);
    cmd_valid = 0;
  endtask
  task poll(input logic [4:0] a, input logic [15:0] ax, input logic [15:0] exp);
    send(a, hlax_pkg::OP_POLL, ax);
    repeat (1500) if (rsp_valid !== 1'b1 && rsp_timeout !== 1'b1) @(negedge core_clk);
    if (rsp_valid !== 1'b1 && rsp_timeout !== 1'b1) tmo();
    if (a == my_addr) chk(rsp_data, exp);
    if (a == my_addr) chk({rsp_valid, 10'h0, rsp_addr}, {1'b1, 10'h0, a});
    else chk({15'h0, rsp_timeout}, 16'h0001);
  endtask
  task step(input int ax, input int n);
    repeat (n < 0 ? -n : n) begin
      @(negedge core_clk);
      ph[ax] = (ph[ax] + (n < 0 ? 3 : 1)) % 4;
      {enc_a[ax], enc_b[ax]} = g[ph[ax]];
      repeat (4) @(negedge core_clk);
    end
  endtask
  task wmot(input int ax, input logic [5:0] exp);
    repeat (1500) if ({mot_slew[ax], mot_track[ax]} !== exp[1:0]) @(negedge core_clk);
    if ({mot_slew[ax], mot_track[ax]} !== exp[1:0]) tmo();
    chk({10'h0, mot_slew[ax], mot_track[ax], mot_dir[ax], 3'h0}, {10'h0, exp[1:0], exp[2], 3'h0});
  endtask
  task t_enc();
    step(0, 6);
    poll(5'h03, 16'h0000, 16'h0006);
    step(0, -8);
    poll(5'h03, 16'h0000, 16'h1ffe);
    step(0, 10);
    poll(5'h03, 16'h0000, 16'h0008);
    poll(5'h09, 16'h0000, 16'h0000);
    $display("encoder test done");
  endtask
  task t_motor();
    send(5'h03, hlax_pkg::OP_TGT_AZ, 16'h006c);
    send(5'h03, hlax_pkg::OP_CMD, 16'h0001);
    wmot(0, 6'h06);
    send(5'h03, hlax_pkg::OP_TGT_AZ, 16'h000d);
    wmot(0, 6'h05);
    send(5'h03, hlax_pkg::OP_TGT_AZ, 16'h0008);
    wmot(0, 6'h04);
    $display("motor test done");
  endtask
  task t_fault();
    @(negedge core_clk);
    {enc_a[1], enc_b[1]} = 2'h3;
    poll(5'h03, 16'h0000, 16'h8008);
    send(5'h03, hlax_pkg::OP_CMD, 16'h0002);
    {enc_a[1], enc_b[1]} = 2'h0;
    poll(5'h03, 16'h0000, 16'h0008);
    $display("fault test done");
  endtask
  task t_manual();
    manual_present = 1;
    manual_fwd = 2'h2;
    wmot(1, 6'h05);
    poll(5'h03, 16'h0000, 16'h4008);
    $display("manual test done");
  endtask
  initial begin
    #(50 * 100000) tmo();
  end
  initial begin
    repeat (10) @(negedge core_clk);
    chk({10'h0, mot_slew, mot_track, mot_dir}, 16'h0000);
    chk({15'h0, bus.dev_oe}, 16'h0000);
    rst_n = 1;
    t_enc();
    t_motor();
    t_fault();
    t_manual();
    stop_test();
  end
endmodule // heliostat_axis_controller_tb
